// file: tge_regs.svh
// register offsets, field positions and reset values for the tuner gain/enable bank
`ifndef TGE_REGS_SVH
`define TGE_REGS_SVH

// ----------------------------------------------------------------------------
// offsets (register index; byte address is four times the index)
// ----------------------------------------------------------------------------
`define TGE_IDX_BB_AMP_OFFSET 6'h1F
`define TGE_IDX_RF_AMP_BIAS 6'h20
`define TGE_IDX_SYS_ENABLE 6'h21

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define TGE_RST_BB_AMP_OFFSET 8'h00
`define TGE_RST_RF_AMP_BIAS 8'h00
`define TGE_RST_SYS_ENABLE 8'h00
`define TGE_MASK_BB_AMP_OFFSET 8'h3F
`define TGE_MASK_RF_AMP_BIAS 8'h1C
`define TGE_MASK_SYS_ENABLE 8'h3D
`define TGE_RST_READDATA 32'h00000000
`define TGE_RST_WAIT 1'b1
`define TGE_READ_PAD 24'h000000
`define TGE_UNMAPPED_VALUE 8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define TGE_ADDR_IDX_MSB 7
`define TGE_ADDR_IDX_LSB 2
`define TGE_BB2_MSB 5
`define TGE_BB2_LSB 3
`define TGE_BB1_MSB 2
`define TGE_BB1_LSB 0
`define TGE_RF_BIAS_DIS_BIT 4
`define TGE_RF_OFF_MSB 3
`define TGE_RF_OFF_LSB 2
`define TGE_CP_BIT 5
`define TGE_PS_BIT 4
`define TGE_BB_BIT 3
`define TGE_DCC_BIT 2
`define TGE_RF_EN_BIT 0

`endif

// file: tge_pkg.sv
// types shared by the tuner gain/enable register bank
package tge_pkg;

  // rf amplifier offset select codes
  typedef enum logic [1:0] {
    TGE_RF_OFF_M70DB = 2'h0,
    TGE_RF_OFF_M67DB = 2'h1,
    TGE_RF_OFF_M64DB = 2'h2,
    TGE_RF_OFF_M61DB = 2'h3
  } tge_rf_off_t;

  // bus slave answer phase
  typedef enum logic [0:0] {
    TGE_IDLE,
    TGE_DONE
  } tge_state_t;

endpackage : tge_pkg

// file: tge_bank.sv
// tuner gain and enable register bank, Avalon-MM slave
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ns
`include "tge_regs.svh"

module tge_bank
  import tge_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [2:0] bb_amp2_offset,
  output logic [2:0] bb_amp1_offset,
  output logic rf_amp_bias_ctl_disable,
  output tge_rf_off_t rf_amp_offset_sel,
  output logic charge_pump_on,
  output logic prescaler_on,
  output logic baseband_on,
  output logic dc_offset_corr_on,
  output logic rf_amp_on
);

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  logic [7:0] bb_off_reg, bb_off_next;
  logic [7:0] rf_reg, rf_next;
  logic [7:0] sys_reg, sys_next;
  logic [31:0] rdata_reg, rdata_next;
  tge_state_t state_reg, state_next;
  logic wait_reg, wait_next;

  // byte address to word index; low address bits are ignored
  function automatic logic [5:0] word_idx(input logic [7:0] a);
    word_idx = a[`TGE_ADDR_IDX_MSB:`TGE_ADDR_IDX_LSB];
  endfunction : word_idx

  // mask a stored value so reserved bits always read zero
  function automatic logic [7:0] reg_read(input logic [5:0] idx, input logic [7:0] b,
                                          input logic [7:0] r, input logic [7:0] s);
    case (idx)
      `TGE_IDX_BB_AMP_OFFSET: reg_read = b & `TGE_MASK_BB_AMP_OFFSET;
      `TGE_IDX_RF_AMP_BIAS: reg_read = r & `TGE_MASK_RF_AMP_BIAS;
      `TGE_IDX_SYS_ENABLE: reg_read = s & `TGE_MASK_SYS_ENABLE;
      default: reg_read = `TGE_UNMAPPED_VALUE; // unmapped reads as zero, writes dropped
    endcase
  endfunction : reg_read

  // --------------------------------------------------------------------------
  // next state: one cycle wait, answer in the second cycle of the request
  // --------------------------------------------------------------------------
  // the fixed wait keeps readdata registered and gives the master a clean edge
  always_comb begin
    bb_off_next = bb_off_reg;
    rf_next = rf_reg;
    sys_next = sys_reg;
    rdata_next = rdata_reg;
    state_next = state_reg;
    case (state_reg)
      TGE_IDLE: begin
        if (read || write) begin
          state_next = TGE_DONE;
          rdata_next = {`TGE_READ_PAD, reg_read(word_idx(address), bb_off_reg, rf_reg, sys_reg)};
          if (write) begin
            case (word_idx(address))
              `TGE_IDX_BB_AMP_OFFSET: bb_off_next = writedata[7:0] & `TGE_MASK_BB_AMP_OFFSET;
              `TGE_IDX_RF_AMP_BIAS: rf_next = writedata[7:0] & `TGE_MASK_RF_AMP_BIAS;
              `TGE_IDX_SYS_ENABLE: sys_next = writedata[7:0] & `TGE_MASK_SYS_ENABLE;
              default: ;
            endcase
          end
        end
      end
      TGE_DONE: state_next = TGE_IDLE;
      default: state_next = TGE_IDLE;
    endcase
    // waitrequest gets its own flop so the bus answer leaves a register like every output
    wait_next = (state_next == TGE_IDLE);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      bb_off_reg <= `TGE_RST_BB_AMP_OFFSET;
      rf_reg <= `TGE_RST_RF_AMP_BIAS;
      sys_reg <= `TGE_RST_SYS_ENABLE;
      rdata_reg <= `TGE_RST_READDATA;
      wait_reg <= `TGE_RST_WAIT;
      state_reg <= TGE_IDLE;
    end else begin
      bb_off_reg <= bb_off_next;
      rf_reg <= rf_next;
      sys_reg <= sys_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      wait_reg <= wait_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // --------------------------------------------------------------------------
  assign readdata = rdata_reg;
  assign waitrequest = wait_reg; // high except in the answer cycle
  assign bb_amp2_offset = bb_off_reg[`TGE_BB2_MSB:`TGE_BB2_LSB];
  assign bb_amp1_offset = bb_off_reg[`TGE_BB1_MSB:`TGE_BB1_LSB];
  // 0 lets the analog side shut bias of idle stages, 1 keeps it biased
  assign rf_amp_bias_ctl_disable = rf_reg[`TGE_RF_BIAS_DIS_BIT];
  assign rf_amp_offset_sel = tge_rf_off_t'(rf_reg[`TGE_RF_OFF_MSB:`TGE_RF_OFF_LSB]);
  // enables are active high, matching the stored bit
  assign charge_pump_on = sys_reg[`TGE_CP_BIT];
  assign prescaler_on = sys_reg[`TGE_PS_BIT];
  assign baseband_on = sys_reg[`TGE_BB_BIT];
  assign dc_offset_corr_on = sys_reg[`TGE_DCC_BIT];
  assign rf_amp_on = sys_reg[`TGE_RF_EN_BIT];

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  // properties watch the registers and outputs of this module; the bus inputs serve as antecedents
  // that say a transfer was taken at the previous edge, and writedata also as $past values in the consequents

  // system enable: written bits land at the taking edge and are checked one edge later
  a_sys_write_takes: assert property (@(posedge clk) disable iff (reset)
    (state_reg == TGE_IDLE && write && word_idx(address) == `TGE_IDX_SYS_ENABLE)
    |=> (charge_pump_on == $past(writedata[`TGE_CP_BIT])
         && rf_amp_on == $past(writedata[`TGE_RF_EN_BIT])))
    else $error("system enable write not applied");
  a_sys_mid_takes: assert property (@(posedge clk) disable iff (reset)
    (state_reg == TGE_IDLE && write && word_idx(address) == `TGE_IDX_SYS_ENABLE)
    |=> (prescaler_on == $past(writedata[`TGE_PS_BIT])
         && baseband_on == $past(writedata[`TGE_BB_BIT])
         && dc_offset_corr_on == $past(writedata[`TGE_DCC_BIT])))
    else $error("system enable middle bits not applied");
  a_sys_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    (sys_reg & ~`TGE_MASK_SYS_ENABLE) == 8'h00)
    else $error("reserved enable bits set");
  a_sys_enable_hold: assert property (@(posedge clk) disable iff (reset)
    !(write && state_reg == TGE_IDLE && word_idx(address) == `TGE_IDX_SYS_ENABLE)
    |=> $stable(sys_reg))
    else $error("system enable changed without write");

  // rf amplifier control: fields follow writes and hold otherwise
  a_rf_write_takes: assert property (@(posedge clk) disable iff (reset)
    (state_reg == TGE_IDLE && write && word_idx(address) == `TGE_IDX_RF_AMP_BIAS)
    |=> (rf_amp_bias_ctl_disable == $past(writedata[4])
         && rf_amp_offset_sel == tge_rf_off_t'($past(writedata[3:2]))))
    else $error("rf amp write not applied");
  a_rf_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    (rf_reg & ~`TGE_MASK_RF_AMP_BIAS) == 8'h00)
    else $error("reserved rf amp bits set");
  a_rf_bias_hold: assert property (@(posedge clk) disable iff (reset)
    !(write && state_reg == TGE_IDLE && word_idx(address) == `TGE_IDX_RF_AMP_BIAS)
    |=> $stable(rf_amp_bias_ctl_disable))
    else $error("bias disable changed without write");
  a_rf_offset_hold: assert property (@(posedge clk) disable iff (reset)
    !(write && state_reg == TGE_IDLE && word_idx(address) == `TGE_IDX_RF_AMP_BIAS)
    |=> $stable(rf_amp_offset_sel))
    else $error("rf offset changed without write");

  // baseband offsets: both stage codes follow writes and hold otherwise
  a_bb_write_takes: assert property (@(posedge clk) disable iff (reset)
    (state_reg == TGE_IDLE && write && word_idx(address) == `TGE_IDX_BB_AMP_OFFSET)
    |=> (bb_amp2_offset == $past(writedata[5:3])
         && bb_amp1_offset == $past(writedata[2:0])))
    else $error("baseband offset write not applied");
  a_bb_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    (bb_off_reg & ~`TGE_MASK_BB_AMP_OFFSET) == 8'h00)
    else $error("reserved baseband bits set");
  a_bb_offset_hold: assert property (@(posedge clk) disable iff (reset)
    !(write && state_reg == TGE_IDLE && word_idx(address) == `TGE_IDX_BB_AMP_OFFSET)
    |=> $stable(bb_off_reg))
    else $error("baseband offset changed without write");

  // read back: a read never writes, so the outputs still show what was read
  a_bb_read_back: assert property (@(posedge clk) disable iff (reset)
    (state_reg == TGE_IDLE && read && !write && word_idx(address) == `TGE_IDX_BB_AMP_OFFSET)
    |=> readdata == {26'h0, bb_amp2_offset, bb_amp1_offset})
    else $error("baseband offset read back wrong");
  a_rf_read_back: assert property (@(posedge clk) disable iff (reset)
    (state_reg == TGE_IDLE && read && !write && word_idx(address) == `TGE_IDX_RF_AMP_BIAS)
    |=> readdata == {27'h0, rf_amp_bias_ctl_disable, rf_amp_offset_sel, 2'h0})
    else $error("rf amp read back wrong");
  a_sys_read_back: assert property (@(posedge clk) disable iff (reset)
    (state_reg == TGE_IDLE && read && !write && word_idx(address) == `TGE_IDX_SYS_ENABLE)
    |=> readdata == {26'h0, charge_pump_on, prescaler_on, baseband_on, dc_offset_corr_on,
                     1'b0, rf_amp_on})
    else $error("system enable read back wrong");
  a_unmapped_read_zero: assert property (@(posedge clk) disable iff (reset) // unmapped word
    (state_reg == TGE_IDLE && read && !write
     && word_idx(address) != `TGE_IDX_BB_AMP_OFFSET
     && word_idx(address) != `TGE_IDX_RF_AMP_BIAS
     && word_idx(address) != `TGE_IDX_SYS_ENABLE)
    |=> readdata == 32'h00000000)
    else $error("unmapped word read not zero");

  // bus handshake: one answer cycle per taken request, idle otherwise
  a_bus_answer_next: assert property (@(posedge clk) disable iff (reset) // bus handshake
    (state_reg == TGE_IDLE && (read || write)) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle after request");
  a_bus_idle_wait: assert property (@(posedge clk) disable iff (reset) // bus handshake
    (state_reg == TGE_IDLE && !read && !write) |=> waitrequest)
    else $error("bus answered without a request");

  // reset: checked one edge later so no history from before time zero is needed
  a_reset_clears_all: assert property (@(posedge clk)
    reset |=> (sys_reg == `TGE_RST_SYS_ENABLE && rf_reg == `TGE_RST_RF_AMP_BIAS
               && bb_off_reg == `TGE_RST_BB_AMP_OFFSET && readdata == `TGE_RST_READDATA
               && waitrequest))
    else $error("state not cleared by reset");

endmodule : tge_bank

// file: tge_bank_bench.sv
// self-checking bench for the tuner gain and enable register bank
`timescale 1ns/1ns
module tge_bank_bench;
  import tge_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd_v;
  logic waitrequest, rf_bias, cp, ps, bb, dcc, rf_en;
  logic [2:0] bb2, bb1;
  tge_rf_off_t rf_sel;
  int errors = 0;
  int checked = 0;
  int mdl[3] = '{0, 0, 0};
  int addr_q[3] = '{8'h7C, 8'h80, 8'h84};
  int mask_q[3] = '{8'h3F, 8'h1C, 8'h3D};
  // ----------------------------------------------------------------------
  // clock and design
  // ----------------------------------------------------------------------
  always #25 clk = ~clk;
  tge_bank dut_u (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .bb_amp2_offset(bb2), .bb_amp1_offset(bb1), .rf_amp_bias_ctl_disable(rf_bias),
    .rf_amp_offset_sel(rf_sel), .charge_pump_on(cp), .prescaler_on(ps), .baseband_on(bb),
    .dc_offset_corr_on(dcc), .rf_amp_on(rf_en));
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one avalon transfer; an idle edge follows so a request is never re-raised in the same step
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    // no cycle count is assumed; only the watchdog ends a wait that never finishes
    while (waitrequest !== 1'b0) @(posedge clk);
    rd_v = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus
  // write a register and mirror only its writable bits in the model
  task automatic wr(int i, logic [31:0] d);
    bus(1'b1, addr_q[i][7:0], d);
    mdl[i] = d & mask_q[i];
  endtask : wr
  // read back every register, an unmapped word, and all analog-side outputs
  task automatic chk_all();
    chk("waitrequest_idle", 32'h1, waitrequest); // bus idle between transfers
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, addr_q[i][7:0], 32'h0);
      chk("readdata", mdl[i], rd_v);
    end
    chk("bb_offsets", mdl[0], {bb2, bb1});
    chk("rf_amp", mdl[1], {rf_bias, rf_sel, 2'b00});
    chk("enables", mdl[2], {cp, ps, bb, dcc, 1'b0, rf_en});
    bus(1'b0, 8'h88, 32'h0);
    chk("unmapped", 32'h0, rd_v);
  endtask : chk_all
  task automatic results();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'hBF8345CD));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_all();
    // every offset code, reserved bits set high to show they are dropped
    for (int c = 0; c < 4; c++) begin
      wr(1, 32'hFFFFFFE3 | (c << 2));
      chk("offset_sel", c, rf_sel);
    end
    wr(1, 32'h10);
    chk_all();
    // walking one through the enables, including the reserved bit 1
    for (int b = 0; b < 6; b++) begin
      wr(2, 32'h1 << b);
      chk_all();
    end
    wr(2, 32'h00);
    chk_all();
    wr(2, 32'h3F);
    chk_all();
    repeat (20) begin
      wr($urandom_range(2), $urandom);
      bus(1'b1, 8'h88, $urandom);
      chk_all();
    end
    // fill every register so the reset below has something to clear
    for (int i = 0; i < 3; i++) wr(i, 32'hFFFFFFFF);
    // reset in mid-run must clear everything again
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    mdl = '{0, 0, 0};
    @(posedge clk);
    chk_all();
    results();
  end
  // watchdog well beyond the roughly 550 cycles the sequence needs
  initial begin
    #500000;
    errors++;
    results();
  end
endmodule : tge_bank_bench
